// file: led_diag_regs.sv
// Purpose: Frame receiver, register bank and read responder of the LED diagnostic block.
// Assumes: Bytes arrive already deframed from the UART; PWM tick comes from the divider.
// Notes: Frames are buffered and applied only after the trailer checks good.
`include "led_diag_consts.svh"
`default_nettype none
module led_diag_regs
  import led_diag_pkg::*;
(
  input wire logic CLK_SYS_IN,
  input wire logic RST_N_IN,
  input wire logic [2:0] DEVICE_ID_IN,
  input wire logic [7:0] RX_BYTE_IN,
  input wire logic RX_VALID_IN,
  input wire logic COMM_RESET_IN,
  input wire logic TX_READY_IN,
  input wire logic PWM_TICK_IN,
  input wire logic SYNC_IN,
  input wire logic WDT_EXPIRED_IN,
  input wire logic [11:0] SWITCH_CLOSE_IN,
  input wire logic [11:0] FAULT_DETECT_IN,
  output logic [7:0] TX_BYTE_OUT,
  output logic TX_VALID_OUT,
  output logic LED_FORCE_ACTIVE_OUT,
  output logic [11:0] LED_FORCE_STATE_OUT,
  output logic [9:0] PWM_COUNT_OUT,
  output logic [11:0] TURN_ON_ENABLE_OUT,
  output logic [11:0] TURN_OFF_ENABLE_OUT,
  output logic [39:0] CLOSE_TIME_G1_OUT,
  output logic [11:0] FAULT_OUT
);
  ////////////////////////////////////////////////////////////////////////////
  frame_state_e state;
  frame_init_s hdr;
  logic [7:0] start_addr;
  logic [3:0] idx;
  logic [3:0] tx_step;
  logic [15:0] crc;
  logic [7:0] data_buf [0:9];
  logic [3:0] frame_len;
  logic [15:0] next_crc;
  logic crc_fail;
  logic reg_wr_en;
  logic [7:0] reg_wr_addr;
  logic [7:0] reg_wr_data;
  logic [7:0] rd_addr;
  logic [7:0] rd_data;
  logic sync_meta, sync_now;
  logic [11:0] det_meta, fault_det;
  logic [11:0] default_state;
  logic [9:0] period_pending;
  logic load_pending;
  logic [7:0] tally;
  logic [3:0][9:0] close_time;
  logic [11:0] fault_keep;
  logic [11:0] fault_set;

  // The sync and fault-detect pins pass two flops before use; the other inputs are used as they arrive.
  always_ff @(posedge CLK_SYS_IN)
  begin
    if (!RST_N_IN)
    begin
      sync_meta <= 1'b0;
      sync_now <= 1'b0;
      det_meta <= `RESET_LED12;
      fault_det <= `RESET_LED12;
    end
    else
    begin
      sync_meta <= SYNC_IN;
      sync_now <= sync_meta;
      det_meta <= FAULT_DETECT_IN;
      fault_det <= det_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    frame_len = byte_count(hdr.count_code);
    next_crc = crc_byte(crc, RX_BYTE_IN);
    // A good trailer leaves a zero residue when run through the same CRC.
    crc_fail = (state == ST_CRC_HI) && RX_VALID_IN && !COMM_RESET_IN && (next_crc != 16'h0000);
    reg_wr_en = (state == ST_COMMIT);
    reg_wr_addr = start_addr + {4'h0, idx};
    reg_wr_data = data_buf[idx];
    rd_addr = start_addr + {4'h0, tx_step} - 8'h01;
  end

  // Frame receive, commit and response sequencing.
  always_ff @(posedge CLK_SYS_IN)
  begin
    if (!RST_N_IN)
    begin
      state <= ST_IDLE;
      hdr <= '0;
      start_addr <= `RESET_BYTE;
      idx <= 4'h0;
      tx_step <= 4'h0;
      crc <= `CRC_INIT;
      TX_BYTE_OUT <= `RESET_BYTE;
      TX_VALID_OUT <= 1'b0;
    end
    else if (COMM_RESET_IN)
    begin
      state <= ST_IDLE;
      TX_VALID_OUT <= 1'b0;
    end
    else
    begin
      unique case (state)
        ST_IDLE:
        begin
          // The top bit marks an init byte; bit 6 picks read over write.
          if (RX_VALID_IN && RX_BYTE_IN[7] && byte_count(RX_BYTE_IN[5:3]) != 4'h0)
          begin
            hdr <= frame_init_s'(RX_BYTE_IN);
            crc <= crc_byte(`CRC_INIT, RX_BYTE_IN);
            state <= ST_ADDR;
          end
        end
        ST_ADDR:
        begin
          if (RX_VALID_IN)
          begin
            start_addr <= RX_BYTE_IN;
            crc <= next_crc;
            idx <= 4'h0;
            state <= hdr.is_read ? ST_CRC_LO : ST_DATA;
          end
        end
        ST_DATA:
        begin
          if (RX_VALID_IN)
          begin
            data_buf[idx] <= RX_BYTE_IN;
            crc <= next_crc;
            idx <= idx + 4'h1;
            if (idx == frame_len - 4'h1)
            begin
              state <= ST_CRC_LO;
            end
          end
        end
        ST_CRC_LO:
        begin
          if (RX_VALID_IN)
          begin
            crc <= next_crc;
            state <= ST_CRC_HI;
          end
        end
        ST_CRC_HI:
        begin
          if (RX_VALID_IN)
          begin
            idx <= 4'h0;
            tx_step <= 4'h0;
            if (crc_fail || hdr.dev_id != DEVICE_ID_IN)
            begin
              state <= ST_IDLE;
            end
            else
            begin
              state <= hdr.is_read ? ST_RESP : ST_COMMIT;
            end
          end
        end
        ST_COMMIT:
        begin
          idx <= idx + 4'h1;
          if (idx == frame_len - 4'h1)
          begin
            state <= ST_IDLE;
          end
        end
        ST_RESP:
        begin
          if (!TX_VALID_OUT || TX_READY_IN)
          begin
            tx_step <= tx_step + 4'h1;
            TX_VALID_OUT <= 1'b1;
            if (tx_step == 4'h0)
            begin
              TX_BYTE_OUT <= {5'h00, hdr.count_code};
              crc <= crc_byte(`CRC_INIT, {5'h00, hdr.count_code});
            end
            else if (tx_step <= frame_len)
            begin
              TX_BYTE_OUT <= rd_data;
              crc <= crc_byte(crc, rd_data);
            end
            else if (tx_step == frame_len + 4'h1)
            begin
              // Trailer goes out bit-reversed; the bench bit-reverses its own CRC before comparing.
              TX_BYTE_OUT <= reverse_byte(crc[7:0]);
            end
            else if (tx_step == frame_len + 4'h2)
            begin
              TX_BYTE_OUT <= reverse_byte(crc[15:8]);
            end
            else
            begin
              TX_VALID_OUT <= 1'b0;
              state <= ST_IDLE;
            end
          end
        end
        default:
        begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    case (rd_addr)
      `ADDR_ON_EN_LOW: rd_data = TURN_ON_ENABLE_OUT[7:0];
      `ADDR_ON_EN_HIGH: rd_data = {4'h0, TURN_ON_ENABLE_OUT[11:8]};
      `ADDR_OFF_EN_LOW: rd_data = TURN_OFF_ENABLE_OUT[7:0];
      `ADDR_OFF_EN_HIGH: rd_data = {4'h0, TURN_OFF_ENABLE_OUT[11:8]};
      `ADDR_DEFAULT_LOW: rd_data = default_state[7:0];
      `ADDR_DEFAULT_HIGH: rd_data = {4'h0, default_state[11:8]};
      `ADDR_PERIOD_LOW: rd_data = PWM_COUNT_OUT[7:0];
      `ADDR_PERIOD_HIGH: rd_data = {6'h00, PWM_COUNT_OUT[9:8]};
      `ADDR_FAULT_LOW: rd_data = FAULT_OUT[7:0];
      `ADDR_FAULT_HIGH: rd_data = {4'h0, FAULT_OUT[11:8]};
      `ADDR_TALLY: rd_data = tally;
      `ADDR_CLOSE_TIME_UPPER: rd_data = {close_time[3][9:8], close_time[2][9:8],
                                         close_time[1][9:8], close_time[0][9:8]};
      default:
      begin
        if (rd_addr >= `ADDR_CLOSE_TIME_BASE && rd_addr < `ADDR_CLOSE_TIME_UPPER)
          rd_data = close_time[rd_addr[1:0]][7:0];
        else
          rd_data = `RESET_BYTE;
      end
    endcase
  end

  // Enables, default state and close times: plain host-written storage.
  always_ff @(posedge CLK_SYS_IN)
  begin
    if (!RST_N_IN)
    begin
      TURN_ON_ENABLE_OUT <= `RESET_LED12;
      TURN_OFF_ENABLE_OUT <= `RESET_LED12;
      default_state <= `RESET_LED12;
      close_time <= '0;
    end
    else if (reg_wr_en)
    begin
      case (reg_wr_addr)
        `ADDR_ON_EN_LOW: TURN_ON_ENABLE_OUT[7:0] <= reg_wr_data;
        `ADDR_ON_EN_HIGH: TURN_ON_ENABLE_OUT[11:8] <= reg_wr_data[3:0];
        `ADDR_OFF_EN_LOW: TURN_OFF_ENABLE_OUT[7:0] <= reg_wr_data;
        `ADDR_OFF_EN_HIGH: TURN_OFF_ENABLE_OUT[11:8] <= reg_wr_data[3:0];
        `ADDR_DEFAULT_LOW: default_state[7:0] <= reg_wr_data;
        `ADDR_DEFAULT_HIGH: default_state[11:8] <= reg_wr_data[3:0];
        `ADDR_CLOSE_TIME_UPPER:
        begin
          for (int i = 0; i < 4; i++)
          begin
            close_time[i][9:8] <= reg_wr_data[2 * i +: 2];
          end
        end
        default:
        begin
          if (reg_wr_addr >= `ADDR_CLOSE_TIME_BASE && reg_wr_addr < `ADDR_CLOSE_TIME_UPPER)
            close_time[reg_wr_addr[1:0]][7:0] <= reg_wr_data;
        end
      endcase
    end
  end

  // Watchdog takeover: the LED state follows the default bits.
  always_ff @(posedge CLK_SYS_IN)
  begin
    if (!RST_N_IN)
    begin
      LED_FORCE_ACTIVE_OUT <= 1'b0;
      LED_FORCE_STATE_OUT <= `RESET_LED12;
      CLOSE_TIME_G1_OUT <= '0;
    end
    else
    begin
      LED_FORCE_ACTIVE_OUT <= WDT_EXPIRED_IN;
      LED_FORCE_STATE_OUT <= default_state;
      CLOSE_TIME_G1_OUT <= close_time;
    end
  end

  // Period counter; a host write waits for the next sync pulse.
  always_ff @(posedge CLK_SYS_IN)
  begin
    if (!RST_N_IN)
    begin
      PWM_COUNT_OUT <= `RESET_PERIOD;
      period_pending <= `RESET_PERIOD;
      load_pending <= 1'b0;
    end
    else
    begin
      if (sync_now && load_pending)
      begin
        PWM_COUNT_OUT <= period_pending;
      end
      else if (PWM_TICK_IN)
      begin
        PWM_COUNT_OUT <= (PWM_COUNT_OUT == `PERIOD_MAX) ? `RESET_PERIOD : PWM_COUNT_OUT + 10'h001;
      end
      if (reg_wr_en && reg_wr_addr == `ADDR_PERIOD_LOW)
      begin
        period_pending[7:0] <= reg_wr_data;
        load_pending <= 1'b1;
      end
      else if (reg_wr_en && reg_wr_addr == `ADDR_PERIOD_HIGH)
      begin
        period_pending[9:8] <= reg_wr_data[1:0];
        load_pending <= 1'b1;
      end
      else if (sync_now)
      begin
        load_pending <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // A new fault wins over a clear arriving in the same cycle.
  always_comb
  begin
    fault_set = SWITCH_CLOSE_IN & fault_det;
    fault_keep = 12'hFFF;
    if (reg_wr_en && reg_wr_addr == `ADDR_FAULT_LOW)
      fault_keep[7:0] = reg_wr_data;
    else if (reg_wr_en && reg_wr_addr == `ADDR_FAULT_HIGH)
      fault_keep[11:8] = reg_wr_data[3:0];
  end

  always_ff @(posedge CLK_SYS_IN)
  begin
    if (!RST_N_IN)
      FAULT_OUT <= `RESET_LED12;
    else
      FAULT_OUT <= (FAULT_OUT & fault_keep) | fault_set;
  end

  // The tally is not touched by a communications reset.
  always_ff @(posedge CLK_SYS_IN)
  begin
    if (!RST_N_IN)
      tally <= `RESET_BYTE;
    else if (reg_wr_en && reg_wr_addr == `ADDR_TALLY)
      tally <= reg_wr_data;
    else if (crc_fail && tally != `TALLY_MAX)
      tally <= tally + 8'h01;
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RST_N_IN);

  a_wdt_force_state: assert property (WDT_EXPIRED_IN |=> LED_FORCE_ACTIVE_OUT)
    else $error("watchdog expiry not forcing default state");
  a_pwm_wrap_zero: assert property (PWM_TICK_IN && !(sync_now && load_pending) && PWM_COUNT_OUT == 10'h3FF
    |=> PWM_COUNT_OUT == 10'h000)
    else $error("period counter failed to wrap");
  a_pwm_step_one: assert property (PWM_TICK_IN && !(sync_now && load_pending) && PWM_COUNT_OUT != 10'h3FF
    |=> PWM_COUNT_OUT == $past(PWM_COUNT_OUT) + 10'h001)
    else $error("period counter step wrong");
  a_sync_load_value: assert property (sync_now && load_pending |=> PWM_COUNT_OUT == $past(period_pending))
    else $error("pending period not loaded on sync");
  a_no_early_load: assert property (!sync_now && !PWM_TICK_IN |=> $stable(PWM_COUNT_OUT))
    else $error("period counter changed without sync or tick");
  a_fault_latch_set: assert property (|fault_set |=> (FAULT_OUT & $past(fault_set)) == $past(fault_set))
    else $error("sampled fault not latched");
  a_fault_hold_one: assert property (fault_set == 12'h000 |=> (FAULT_OUT & ~$past(FAULT_OUT)) == 12'h000)
    else $error("fault bit set without a fault");
  a_fault_no_clear: assert property (!reg_wr_en |=> (FAULT_OUT & $past(FAULT_OUT)) == $past(FAULT_OUT))
    else $error("fault bit cleared without write");
  a_tally_count_up: assert property (crc_fail && tally != 8'hFF |=> tally == $past(tally) + 8'h01)
    else $error("tally did not count a bad frame");
  a_tally_saturate: assert property (crc_fail && tally == 8'hFF |=> tally == 8'hFF)
    else $error("tally wrapped past all ones");
  a_tally_comm_reset: assert property (COMM_RESET_IN && !reg_wr_en |=> $stable(tally))
    else $error("comm reset disturbed tally");
  a_crc_drop_frame: assert property (crc_fail |=> state == ST_IDLE ##1 !reg_wr_en)
    else $error("bad frame reached commit");

  c_write_commit: cover property (state == ST_CRC_HI && RX_VALID_IN && !crc_fail ##1 reg_wr_en);
  c_read_response: cover property (state == ST_RESP && TX_VALID_OUT && TX_READY_IN);
  c_tally_full: cover property (crc_fail && tally == 8'hFF);
  c_sync_load: cover property (sync_now && load_pending);
endmodule : led_diag_regs
`default_nettype wire

// file: led_diag_consts.svh
// Purpose: Offsets, init bases, CRC constants, reset values and fixed counts of the LED diagnostic register block.
// Assumes: Included by bare name from the package and the design module.
// Notes: Definitions only.
// Function
// - Watchdog expiry forces LEDs to default state bits.
// - Ten-bit PWM period counter counts and wraps.
// - Counter writes load only on sync pulse.
// - Fault sampled before switch closes, latched.
// - Fault bits hold until host writes zero.
// - Writing one to fault bit does nothing.
// - Persisting fault sets bit again next period.
// - CRC error tally increments per failed frame.
// - CRC error tally saturates at all ones.
// - Communications reset leaves tally unchanged.
// - Host may write any tally value.
// - Write frame: init, address, data, CRC.
// - Multi-byte access uses consecutive addresses.
// - Read frame: init, address, CRC only.
// - Response: init, data bytes, two CRC bytes; the code sends the count code alone in place of the init byte.
// - CRC-16 trailer, low byte then high; the code sends each response trailer byte bit-reversed.
// - Init byte carries target device identifier.
// - On-enable registers map one bit per LED.
// - Shared high byte packs four upper pairs.
// - Write init ORs 0x80, read ORs 0xC0.
// - CRC starts zero, LSB first, poly 0xA001.
`ifndef LED_DIAG_CONSTS_SVH
`define LED_DIAG_CONSTS_SVH
`define ADDR_CLOSE_TIME_BASE 8'h20
`define ADDR_CLOSE_TIME_UPPER 8'h24
`define ADDR_ON_EN_LOW 8'hB0
`define ADDR_ON_EN_HIGH 8'hB1
`define ADDR_OFF_EN_LOW 8'hB2
`define ADDR_OFF_EN_HIGH 8'hB3
`define ADDR_DEFAULT_LOW 8'hC2
`define ADDR_DEFAULT_HIGH 8'hC3
`define ADDR_PERIOD_LOW 8'hC4
`define ADDR_PERIOD_HIGH 8'hC5
`define ADDR_FAULT_LOW 8'hE0
`define ADDR_FAULT_HIGH 8'hE1
`define ADDR_TALLY 8'hE2
`define INIT_WRITE_BASE 8'h80
`define INIT_READ_BASE 8'hC0
`define CRC_POLY 16'hA001
`define CRC_INIT 16'h0000
`define PERIOD_MAX 10'h3FF
`define TALLY_MAX 8'hFF
`define RESET_BYTE 8'h00
`define RESET_LED12 12'h000
`define RESET_PERIOD 10'h000
`endif

// file: led_diag_pkg.sv
// Purpose: Types and shared arithmetic of the LED diagnostic register block.
// Assumes: Constants come from the guarded header.
// Notes: Frame init byte is {1, read, count code[2:0], device id[2:0]}.
`include "led_diag_consts.svh"
`default_nettype none
package led_diag_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_ADDR = 3'b001, ST_DATA = 3'b010, ST_CRC_LO = 3'b011,
    ST_CRC_HI = 3'b100, ST_COMMIT = 3'b101, ST_RESP = 3'b110
  } frame_state_e;
  typedef struct packed {
    logic start;
    logic is_read;
    logic [2:0] count_code;
    logic [2:0] dev_id;
  } frame_init_s;
  function automatic logic [15:0] crc_byte(input logic [15:0] crc_in, input logic [7:0] data);
    logic [15:0] c;
    c = crc_in ^ {8'h00, data};
    for (int i = 0; i < 8; i++)
    begin
      c = c[0] ? ((c >> 1) ^ `CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction : crc_byte
  function automatic logic [7:0] reverse_byte(input logic [7:0] b);
    return {b[0], b[1], b[2], b[3], b[4], b[5], b[6], b[7]};
  endfunction : reverse_byte
  function automatic logic [3:0] byte_count(input logic [2:0] code);
    case (code)
      3'h0: return 4'h1;
      3'h1: return 4'h2;
      3'h2: return 4'h5;
      3'h3: return 4'hA;
      default: return 4'h0;
    endcase
  endfunction : byte_count
endpackage : led_diag_pkg
`default_nettype wire

// file: led_host_model.sv
// Purpose: Host end of the serial link; frames requests with a CRC trailer and collects responses.
// Assumes: Bytes change just after the falling clock edge, one per cycle.
// Notes: A stall count holds off acceptance of response bytes.
`default_nettype none
module led_host_model
(
  input wire logic clk_in,
  input wire logic [7:0] tx_byte_in,
  input wire logic tx_valid_in,
  output logic [7:0] rx_byte_out,
  output logic rx_valid_out,
  output logic tx_ready_out
);
  typedef logic [7:0] byte_t;
  initial
  begin
    rx_byte_out = 8'h00;
    rx_valid_out = 1'b0;
    tx_ready_out = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] crc16(input byte_t b[$]);
    logic [15:0] c;
    c = 16'h0000;
    foreach (b[i])
    begin
      c = c ^ {8'h00, b[i]};
      for (int k = 0; k < 8; k++)
      begin
        c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
      end
    end
    return c;
  endfunction : crc16
  function automatic byte_t init_of(input logic rd, input int n, input logic [2:0] id);
    logic [2:0] code;
    code = (n == 1) ? 3'h0 : (n == 2) ? 3'h1 : (n == 5) ? 3'h2 : 3'h3;
    return (rd ? 8'hC0 : 8'h80) | {2'b00, code, id};
  endfunction : init_of
  ////////////////////////////////////////////////////////////////////////////////
  // A bad trailer flips one CRC bit so the device must reject the frame.
  task automatic send(input byte_t f[$], input logic bad);
    logic [15:0] c;
    c = crc16(f) ^ {15'h0000, bad};
    f.push_back(c[7:0]);
    f.push_back(c[15:8]);
    foreach (f[i])
    begin
      @(negedge clk_in);
      rx_byte_out <= f[i];
      rx_valid_out <= 1'b1;
    end
    @(negedge clk_in);
    rx_valid_out <= 1'b0;
    rx_byte_out <= ~rx_byte_out;
  endtask : send
  task automatic wr(input logic [2:0] id, input byte_t a, input byte_t d[$], input logic bad);
    byte_t f[$];
    f = {init_of(1'b0, d.size(), id), a};
    f = {f, d};
    send(f, bad);
  endtask : wr
  task automatic recv(input int n, input int stall, output byte_t r[$], output logic ok);
    int w;
    r = {};
    ok = 1'b1;
    for (int i = 0; i < n; i++)
    begin
      w = 0;
      @(negedge clk_in);
      while (tx_valid_in !== 1'b1 && w < 50)
      begin
        @(negedge clk_in);
        w++;
      end
      if (w == 50)
        ok = 1'b0;
      repeat (stall) @(negedge clk_in);
      // The offered byte stands until accepted, so it is taken while settled.
      r.push_back(tx_byte_in);
      tx_ready_out <= 1'b1;
      @(posedge clk_in);
      @(negedge clk_in);
      tx_ready_out <= 1'b0;
    end
  endtask : recv
  task automatic rd(input logic [2:0] id, input byte_t a, input int n, input int stall,
                    output byte_t r[$], output logic ok);
    send({init_of(1'b1, n, id), a}, 1'b0);
    recv(n + 3, stall, r, ok);
  endtask : rd
endmodule : led_host_model
`default_nettype wire

// file: tb_led_diag_regs.sv
// Purpose: Self-checking bench of the LED diagnostic register block.
// Assumes: Inputs change at the falling clock edge.
// Notes: Expected values come from the host model's own CRC and the register layout.
`default_nettype none
module tb_led_diag_regs;
  import led_diag_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_n = 1'b0, comm_reset = 1'b0, pwm_tick = 1'b0, sync = 1'b0, wdt = 1'b0;
  logic [2:0] dev_id = 3'h5;
  logic [11:0] sw_close = 12'h000, fault_det = 12'h000, force_state, fault, on_en, off_en;
  logic [7:0] rx_byte, tx_byte;
  logic rx_valid, tx_ready, tx_valid, force_active;
  logic [9:0] pwm_count;
  logic [39:0] close_g1;
  int err_count = 0;
  int n_checks = 0;
  initial
  begin
    forever #20 clk = ~clk;
  end
  led_diag_regs led_diag_regs_i (.CLK_SYS_IN(clk), .RST_N_IN(rst_n), .DEVICE_ID_IN(dev_id),
    .RX_BYTE_IN(rx_byte), .RX_VALID_IN(rx_valid), .COMM_RESET_IN(comm_reset), .TX_READY_IN(tx_ready),
    .PWM_TICK_IN(pwm_tick), .SYNC_IN(sync), .WDT_EXPIRED_IN(wdt), .SWITCH_CLOSE_IN(sw_close),
    .FAULT_DETECT_IN(fault_det), .TX_BYTE_OUT(tx_byte), .TX_VALID_OUT(tx_valid),
    .LED_FORCE_ACTIVE_OUT(force_active), .LED_FORCE_STATE_OUT(force_state), .PWM_COUNT_OUT(pwm_count),
    .TURN_ON_ENABLE_OUT(on_en), .TURN_OFF_ENABLE_OUT(off_en), .CLOSE_TIME_G1_OUT(close_g1),
    .FAULT_OUT(fault));
  led_host_model led_host_model_i (.clk_in(clk), .tx_byte_in(tx_byte), .tx_valid_in(tx_valid),
    .rx_byte_out(rx_byte), .rx_valid_out(rx_valid), .tx_ready_out(tx_ready));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop
  task automatic check(input logic [47:0] got, input logic [47:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  function automatic logic [7:0] rev(input logic [7:0] b);
    return {b[0], b[1], b[2], b[3], b[4], b[5], b[6], b[7]};
  endfunction : rev
  task automatic cycles(input int n);
    repeat (n) @(negedge clk);
  endtask : cycles
  // Commit of a frame takes at most ten cycles after its trailer.
  task automatic wr(input logic [7:0] a, input logic [7:0] d[$], input logic bad);
    led_host_model_i.wr(dev_id, a, d, bad);
    cycles(14);
  endtask : wr
  task automatic rd1(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] r[$];
    logic ok;
    led_host_model_i.rd(dev_id, a, 1, 0, r, ok);
    check(ok, 1'b1);
    if (!ok)
      report_and_stop();
    check(r[0], 8'h00);
    check(r[1], exp);
  endtask : rd1
  task automatic pulse(ref logic s);
    @(negedge clk);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask : pulse
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_enables();
    check(led_host_model_i.crc16({8'h8D, 8'hB0, 8'h55, 8'h05}), 16'hD8D5);
    check(led_host_model_i.crc16({8'hD0, 8'h20}), 16'h185C);
    led_host_model_i.wr(3'h4, 8'hB0, {8'hFF, 8'hFF}, 1'b0);
    cycles(14);
    check(on_en, 12'h000);
    wr(8'hB0, {8'h55, 8'h05}, 1'b0);
    check(on_en, 12'h555);
    wr(8'hB2, {8'h0A, 8'h0A}, 1'b0);
    check(off_en, 12'hA0A);
  endtask : t_enables
  task automatic t_close();
    logic [7:0] r[$];
    logic ok;
    logic [15:0] c;
    dev_id = 3'h0;
    check(led_host_model_i.crc16({8'h90, 8'h20, 8'hC8, 8'h9A, 8'h6C, 8'h3E, 8'hE4}), 16'h5788);
    wr(8'h20, {8'hC8, 8'h9A, 8'h6C, 8'h3E, 8'hE4}, 1'b0);
    check(close_g1, {10'h33E, 10'h26C, 10'h19A, 10'h0C8});
    led_host_model_i.rd(3'h0, 8'h20, 5, 3, r, ok);
    check(ok, 1'b1);
    if (!ok)
      report_and_stop();
    check({r[0], r[1], r[2], r[3], r[4], r[5]}, 48'h02C89A6C3EE4);
    c = led_host_model_i.crc16(r[0:5]);
    check({r[7], r[6]}, {rev(c[15:8]), rev(c[7:0])});
    cycles(2);
    check(tx_valid, 1'b0);
  endtask : t_close
  task automatic t_default();
    wr(8'hC2, {8'hA5, 8'hFF}, 1'b0);
    check(force_state, 12'hFA5);
    rd1(8'hC3, 8'h0F);
    wdt = 1'b1;
    cycles(2);
    check({force_active, force_state}, 13'h1FA5);
    wdt = 1'b0;
  endtask : t_default
  task automatic t_period();
    wr(8'hC4, {8'hFE, 8'hFF}, 1'b0);
    check(pwm_count, 10'h000);
    pulse(sync);
    cycles(4);
    check(pwm_count, 10'h3FE);
    rd1(8'hC5, 8'h03);
    pulse(pwm_tick);
    pulse(pwm_tick);
    cycles(1);
    check(pwm_count, 10'h000);
  endtask : t_period
  task automatic t_fault();
    fault_det = 12'h008;
    cycles(4);
    sw_close = 12'h009;
    cycles(1);
    sw_close = 12'h000;
    cycles(3);
    check(fault, 12'h008);
    fault_det = 12'h000;
    cycles(4);
    wr(8'hE0, {8'hFF, 8'hFF}, 1'b0);
    check(fault, 12'h008);
    wr(8'hE0, {8'h00}, 1'b0);
    check(fault, 12'h000);
    fault_det = 12'h800;
    cycles(4);
    sw_close = 12'h800;
    cycles(1);
    sw_close = 12'h000;
    cycles(3);
    rd1(8'hE1, 8'h08);
    fault_det = 12'h000;
  endtask : t_fault
  task automatic t_tally();
    wr(8'hB0, {8'h00, 8'h00}, 1'b1);
    check(on_en, 12'h555);
    rd1(8'hE2, 8'h01);
    wr(8'hE2, {8'hFE}, 1'b0);
    pulse(comm_reset);
    rd1(8'hE2, 8'hFE);
    wr(8'hC2, {8'h00}, 1'b1);
    rd1(8'hE2, 8'hFF);
    wr(8'hC2, {8'h00}, 1'b1);
    rd1(8'hE2, 8'hFF);
    check(force_state, 12'hFA5);
  endtask : t_tally
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    cycles(10);
    rst_n = 1'b1;
    t_enables();
    t_close();
    t_default();
    t_period();
    t_fault();
    t_tally();
    report_and_stop();
  end
endmodule : tb_led_diag_regs
`default_nettype wire
